// [ext_irq_vector_base.sv]
`timescale 1ns/10ps
`include "ext_irq_defs.svh"
// Overview of operation
// - Relocate non-reset vectors into base-selected 256-byte page
// - Relocated address is base shifted 8 plus default
// - Two independent external interrupt sources, one per pin
// - Pin driven as output still raises interrupts
// - Low-level mode requests while enabled pin stays low
// - Edge detection runs only while I/O clock runs
// - Low-level wake detection is asynchronous, needs no clock
// - Only low-level detection wakes core in deep sleep
// - Pulses longer than one cycle trigger while I/O clock runs
// - Edges found by comparing pin samples, not clocking
// - Trigger control: pin0 bits 1:0, pin1 bits 3:2
// - Request needs global enable and pin mask bit
// - Trigger codes: low, any edge, falling, rising
// - Mask bit gates both interrupt and wake-up
module ext_irq_vector_base (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [1:0] EXT_IRQ_PIN,
  input wire logic IO_CLK_EN,
  input wire logic [1:0] IRQ_ACK,
  output logic [1:0] IRQ_REQ,
  output logic [1:0] WAKE_REQ,
  input wire logic [15:0] VEC_DEFAULT_ADDR,
  input wire logic VEC_IS_RESET,
  output logic [15:0] VEC_ADDR
);

  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;
  logic [1:0] flags_reg;
  logic [1:0] flags_next;
  logic [1:0] mask_reg;
  logic [3:0] trig_reg;
  logic [7:0] vbase_reg;
  logic [1:0] gctrl_reg;
  logic [31:0] rdata_reg;
  logic [15:0] vec_reg;
  logic [1:0] edge_event;
  logic [1:0] level_low;
  logic [1:0] async_low;
  logic [1:0] flag_clr;
  logic [9:0] idx;
  logic aligned;
  logic wr_en;
  logic rd_en;
  logic hit;

  // Trigger mode of one pin from the control field
  function automatic ext_irq_pkg::trigger_mode_t pin_mode(input logic [3:0] trig,
                                                          input int pin);
    pin_mode = ext_irq_pkg::trigger_mode_t'(trig[pin*2 +: 2]);
  endfunction

  // APB decode; every access completes in its first access cycle
  assign idx = PADDR[11:2];
  assign aligned = (PADDR[1:0] == 2'h0);
  assign hit = aligned && (idx == `IDX_FLAGS || idx == `IDX_MASK || idx == `IDX_TRIG ||
                           idx == `IDX_VBASE || idx == `IDX_GCTRL);
  assign wr_en = PSEL && PENABLE && PWRITE && hit;
  assign rd_en = PSEL && !PWRITE && hit;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign PRDATA = rdata_reg;

  // Two-stage synchroniser for the pin levels
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pin_meta_reg <= 2'h3;
      pin_sync_reg <= 2'h3;
    end else begin
      pin_meta_reg <= EXT_IRQ_PIN;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Previous sample, taken only on I/O clock ticks
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      pin_prev_reg <= 2'h3;
    end else if (IO_CLK_EN) begin
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Edge detection by comparing samples, per pin
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      level_low[i] = !pin_sync_reg[i];
      case (pin_mode(trig_reg, i))
        ext_irq_pkg::TRIG_ANY_EDGE: edge_event[i] = pin_sync_reg[i] ^ pin_prev_reg[i];
        ext_irq_pkg::TRIG_FALLING: edge_event[i] = !pin_sync_reg[i] && pin_prev_reg[i];
        ext_irq_pkg::TRIG_RISING: edge_event[i] = pin_sync_reg[i] && !pin_prev_reg[i];
        default: edge_event[i] = 1'b0;
      endcase
      edge_event[i] = edge_event[i] && IO_CLK_EN;
    end
  end

  // Flag clear sources: software write-one or core acknowledge
  always_comb begin
    flag_clr = IRQ_ACK;
    if (wr_en && idx == `IDX_FLAGS) begin
      flag_clr = flag_clr | PWDATA[1:0];
    end
  end

  // Pending flags, a new edge wins over a clear in the same cycle
  assign flags_next = (flags_reg & ~flag_clr) | edge_event;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      flags_reg <= `RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Software-written control registers
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mask_reg <= `RST_MASK;
      trig_reg <= `RST_TRIG;
      vbase_reg <= `RST_VBASE;
      gctrl_reg <= `RST_GCTRL;
    end else if (wr_en) begin
      case (idx)
        `IDX_MASK: mask_reg <= PWDATA[1:0];
        `IDX_TRIG: trig_reg <= PWDATA[3:0];
        `IDX_VBASE: vbase_reg <= PWDATA[7:0];
        `IDX_GCTRL: gctrl_reg <= PWDATA[1:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // Read data, reserved bits read as zero
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      case (idx)
        `IDX_FLAGS: rdata_reg <= {30'h0000_0000, flags_reg};
        `IDX_MASK: rdata_reg <= {30'h0000_0000, mask_reg};
        `IDX_TRIG: rdata_reg <= {28'h000_0000, trig_reg};
        `IDX_VBASE: rdata_reg <= {24'h00_0000, vbase_reg};
        `IDX_GCTRL: rdata_reg <= {30'h0000_0000, gctrl_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end else if (PSEL && !PENABLE) begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Request to core: pending edge or held low level, gated by enables
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (pin_mode(trig_reg, i) == ext_irq_pkg::TRIG_LOW_LEVEL) begin
        IRQ_REQ[i] = level_low[i];
      end else begin
        IRQ_REQ[i] = flags_reg[i];
      end
      IRQ_REQ[i] = IRQ_REQ[i] && mask_reg[i] && gctrl_reg[`GCTRL_GIE_BIT];
    end
  end

  // Clockless wake path straight from the pads, low-level mode only
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      async_low[i] = !EXT_IRQ_PIN[i];
      WAKE_REQ[i] = async_low[i] && mask_reg[i] &&
                    (pin_mode(trig_reg, i) == ext_irq_pkg::TRIG_LOW_LEVEL);
    end
  end

  // Vector address, relocated into the selected page except for reset
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      vec_reg <= 16'h0000;
    end else if (gctrl_reg[`GCTRL_RELOC_BIT] && !VEC_IS_RESET) begin
      vec_reg <= ({8'h00, vbase_reg} << `VBASE_SHIFT) + VEC_DEFAULT_ADDR;
    end else begin
      vec_reg <= VEC_DEFAULT_ADDR;
    end
  end

  assign VEC_ADDR = vec_reg;

endmodule // ext_irq_vector_base

// [ext_irq_defs.svh]
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_FLAGS 10'h03c
`define IDX_MASK 10'h03d
`define IDX_TRIG 10'h069
`define IDX_VBASE 10'h075
`define IDX_GCTRL 10'h076

// Reset values
`define RST_FLAGS 2'h0
`define RST_MASK 2'h0
`define RST_TRIG 4'h0
`define RST_VBASE 8'h00
`define RST_GCTRL 2'h0

// Field positions
`define TRIG_PIN0_LSB 0
`define TRIG_PIN1_LSB 2
`define GCTRL_GIE_BIT 0
`define GCTRL_RELOC_BIT 1

// Relocation page shift
`define VBASE_SHIFT 8

`endif

// [ext_irq_pkg.sv]
package ext_irq_pkg;

  // Trigger select encoding per pin
  typedef enum logic [1:0] {
    TRIG_LOW_LEVEL = 2'h0,
    TRIG_ANY_EDGE = 2'h1,
    TRIG_FALLING = 2'h2,
    TRIG_RISING = 2'h3
  } trigger_mode_t;

endpackage

// [ext_irq_vector_base_chk.sv]
`timescale 1ns/10ps
module ext_irq_vector_base_chk (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PSLVERR,
  input wire logic [1:0] EXT_IRQ_PIN,
  input wire logic IO_CLK_EN,
  input wire logic [1:0] IRQ_ACK,
  input wire logic [1:0] IRQ_REQ,
  input wire logic [1:0] WAKE_REQ,
  input wire logic [15:0] VEC_DEFAULT_ADDR,
  input wire logic VEC_IS_RESET,
  input wire logic [15:0] VEC_ADDR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // Vector mapping, wake path, flag clearing and address decode
  a_vec_reset: assert property (VEC_IS_RESET |=> VEC_ADDR == $past(VEC_DEFAULT_ADDR))
    else $error("reset vector moved");
  a_vec_low: assert property (1'h1 |=> VEC_ADDR[7:0] == $past(VEC_DEFAULT_ADDR[7:0]))
    else $error("vector low byte wrong");
  a_wake_zero: assert property (WAKE_REQ[0] |-> !EXT_IRQ_PIN[0])
    else $error("wake 0 with pin high");
  a_wake_one: assert property (WAKE_REQ[1] |-> !EXT_IRQ_PIN[1])
    else $error("wake 1 with pin high");
  a_ack_zero: assert property ((EXT_IRQ_PIN[0] && IO_CLK_EN) [*5] ##0 IRQ_ACK[0] |=> !IRQ_REQ[0])
    else $error("ack 0 kept request");
  a_ack_one: assert property ((EXT_IRQ_PIN[1] && IO_CLK_EN) [*5] ##0 IRQ_ACK[1] |=> !IRQ_REQ[1])
    else $error("ack 1 kept request");
  a_bad_addr: assert property (PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("unaligned not refused");
  a_map_ok: assert property (PSEL && PENABLE && PADDR inside {12'h0f0, 12'h1a4} |-> !PSLVERR)
    else $error("mapped refused");
endmodule // ext_irq_vector_base_chk
bind ext_irq_vector_base ext_irq_vector_base_chk u_ext_irq_vector_base_chk (.*);

// [ext_pin_src.sv]
`timescale 1ns/10ps
module ext_pin_src (
  input logic clk,
  input logic [1:0] want,
  output logic [1:0] pin
);
  // Pads follow the commanded level, each level held many cycles
  initial pin = 2'h3;
  always @(posedge clk) pin <= want;
endmodule // ext_pin_src

// [test_ext_irq_vector_base.sv]
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_ext_irq_vector_base;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, io_en = 1'h1;
  logic visr = 1'h0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] ack = 2'h0, want = 2'h3, pin, irq, wake;
  logic [15:0] vdef = 16'h0, vaddr, ev;
  logic [11:0] ra[$] = '{12'h0f0, 12'h0f4, 12'h1a4, 12'h1d4, 12'h1d8};
  int err_count = 0, total_checks = 0, b;
  ext_irq_vector_base u_ext_irq_vector_base (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_IRQ_PIN(pin), .IO_CLK_EN(io_en), .IRQ_ACK(ack),
    .IRQ_REQ(irq), .WAKE_REQ(wake), .VEC_DEFAULT_ADDR(vdef), .VEC_IS_RESET(visr),
    .VEC_ADDR(vaddr));
  ext_pin_src u_ext_pin_src (.clk(clk), .want(want), .pin(pin));
  initial forever #50 clk = ~clk;
  // One APB transfer, released only after pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata; er = pslverr; psel <= 1'h0; penable <= 1'h0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    #500000; err_count++; conclude();
  end
  // Main sequence: registers, trigger modes, gating, vectors
  initial begin
    void'($urandom(69));
    wt(6); rst <= 1'h0;
    foreach (ra[i]) begin apb(1'h0, ra[i], 32'h0); `CHK("reset", 32'h0, rd) end
    apb(1'h0, 12'h0f2, 32'h0); `CHK("unaligned", 1'h1, er)
    apb(1'h1, 12'h1d8, 32'h1); apb(1'h1, 12'h0f4, 32'h3);
    apb(1'h0, 12'h0f4, 32'h0); `CHK("mask rd", 32'h3, rd)
    apb(1'h0, 12'h1d8, 32'h0); `CHK("gctrl rd", 32'h1, rd)
    $display("registers done");
    for (int p = 0; p < 2; p++) for (int m = 0; m < 4; m++) begin
      apb(1'h1, 12'h1a4, 32'(m << (2 * p)));
      apb(1'h0, 12'h1a4, 32'h0); `CHK("trig rd", 32'(m << (2 * p)), rd)
      want[p] <= 1'h0; wt(6);
      `CHK("fall", 2'(m != 3) << p, irq)
      `CHK("wake", 2'(m == 0) << p, wake)
      want[p] <= 1'h1; wt(6);
      `CHK("rise", 2'(m != 0) << p, irq)
      ack <= 2'h1 << p; wt(1); ack <= 2'h0; wt(2);
      `CHK("ack", 2'h0, irq)
    end
    $display("triggers done");
    apb(1'h1, 12'h1a4, 32'h0); apb(1'h1, 12'h1d8, 32'h0); want <= 2'h2; wt(6);
    `CHK("gie off", 2'h0, irq)
    `CHK("wake on", 2'h1, wake)
    apb(1'h1, 12'h0f4, 32'h0); wt(1); `CHK("mask off", 2'h0, wake)
    want <= 2'h3; apb(1'h1, 12'h0f4, 32'h3); apb(1'h1, 12'h1d8, 32'h1);
    apb(1'h1, 12'h1a4, 32'h2); io_en <= 1'h0; want <= 2'h2; wt(8);
    `CHK("io stop", 2'h0, irq)
    io_en <= 1'h1; wt(4); `CHK("io run", 2'h1, irq)
    want <= 2'h3; apb(1'h1, 12'h0f0, 32'h3); wt(2); `CHK("w1c", 2'h0, irq)
    $display("gating done");
    for (int k = 0; k < 6; k++) begin
      b = $urandom; vdef <= 16'($urandom); visr <= k[0];
      apb(1'h1, 12'h1d4, 32'(b[7:0])); apb(1'h1, 12'h1d8, {30'h0, k < 4, 1'h1}); wt(2);
      ev = (k < 4 && !k[0]) ? {b[7:0], 8'h00} + vdef : vdef;
      `CHK("vector", ev, vaddr)
      apb(1'h0, 12'h1d4, 32'h0); `CHK("base rd", 32'(b[7:0]), rd)
    end
    $display("vectors done");
    conclude();
  end
endmodule // test_ext_irq_vector_base
